// ===== src/oskc_pkg.sv
package oskc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Structure
  localparam int NUM_OUT = 4;
  localparam int BANK_X_COUNT = 2;
  localparam int SKEW_W = 4;
  localparam int SKEW_STEPS = 16;
  localparam int SKEW_SPAN = SKEW_STEPS - 1;
  // One tick of MCLK stands for one eighth of the oscillator period
  localparam int OSC_TICKS = 8;
  localparam int FINE_DIV = 8;
  localparam int COARSE_DIV = 4;
  localparam int FINE_TICKS = OSC_TICKS / FINE_DIV;
  localparam int COARSE_TICKS = OSC_TICKS / COARSE_DIV;
  localparam int TAP_COUNT = SKEW_SPAN * COARSE_TICKS + 1;
  localparam int TAP_W = $clog2(TAP_COUNT);
  localparam int DIV_W = 7;
  localparam int M_W = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int MCLK_PERIOD_PS = 5000;
  localparam int OE_DELAY_MAX_NS = 20;
  localparam int OE_DELAY_CYC = OE_DELAY_MAX_NS * 1000 / MCLK_PERIOD_PS;
  localparam int LOGIC_RST_NS = 20;
  localparam int LOGIC_RST_CYC = (LOGIC_RST_NS * 1000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int LOOP_RST_MS = 1;
  localparam int LOOP_RST_CYC = (LOOP_RST_MS * 1000000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int LOCK_TIME_US = 15;
  localparam int LOCK_CYC = (LOCK_TIME_US * 1000000 + MCLK_PERIOD_PS - 1) / MCLK_PERIOD_PS;
  localparam int GATE_SETUP_CYCLES = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_VDIV = 8'h04;
  localparam logic [7:0] REG_PROF0 = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h20;
  // Field layout
  localparam int VDIV_STRIDE = 8;
  localparam int PROF_COARSE_BIT = 16;
  localparam int PROF_W = 17;
  localparam int ST_PROF_LSB = 0;
  localparam int ST_LOCK_BIT = 2;
  localparam int ST_LOOPRST_BIT = 3;
  localparam int ST_BYPASS_BIT = 4;
  localparam int ST_LOGICRST_BIT = 5;
  localparam int ST_EN_LSB = 8;
  localparam int ST_GATE_LSB = 12;
  // Reset values
  localparam logic [M_W-1:0] M_RESET = 6'h01;
  localparam logic [DIV_W-1:0] V_RESET = 7'h02;
  localparam logic [PROF_W-1:0] PROF_RESET = 17'h00000;

  // Reset pin evaluation
  typedef enum logic [2:0] {
    RS_IDLE = 3'b001,
    RS_LOGIC = 3'b010,
    RS_LOOP = 3'b100
  } oskc_rst_type;

endpackage

// ===== src/oskc_skew_if.sv
interface oskc_skew_if;
  import oskc_pkg::*;
  logic [NUM_OUT-1:0] raw_clk;
  logic [NUM_OUT-1:0][TAP_W-1:0] tap_sel;
  logic [NUM_OUT-1:0] skewed_clk;
  modport src (output raw_clk, output tap_sel, input skewed_clk);
  modport line (input raw_clk, input tap_sel, output skewed_clk);
endinterface

// ===== src/oskc_skew_line.sv
module oskc_skew_line
(
  input wire logic MCLK,
  input wire logic RST_N,
  oskc_skew_if.line sk
);
  import oskc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // One tapped delay line per output, one tick per stage
  genvar g;
  generate
    for (g = 0; g < NUM_OUT; g++)
    begin : g_line
      logic [TAP_COUNT-1:0] dly_q;
      logic [TAP_COUNT-1:0] dly_d;

      // Shift the undelayed clock in at stage zero
      always_comb
      begin
        dly_d = {dly_q[TAP_COUNT-2:0], sk.raw_clk[g]};
      end

      always_ff @(posedge MCLK or negedge RST_N)
      begin
        if (!RST_N)
          dly_q <= '0;
        else
          dly_q <= dly_d;
      end

      // Tap zero is the reference; each tap above adds one tick
      assign sk.skewed_clk[g] = dly_q[sk.tap_sel[g]];
    end
  endgenerate

endmodule

// ===== src/oskc_top.sv
module oskc_top
#(
  parameter int LOOP_RST_CYCLES = oskc_pkg::LOOP_RST_CYC,
  parameter int LOCK_CYCLES = oskc_pkg::LOCK_CYC
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic REF_IN,
  input wire logic LOOP_BYPASS,
  input wire logic RESET_REQ_N,
  input wire logic [1:0] PROFILE_SELECT,
  input wire logic BANK_X_OUTPUT_ENABLE,
  input wire logic BANK_Y_OUTPUT_ENABLE,
  input wire logic GLOBAL_OUTPUT_ENABLE,
  input wire logic SYNCHRONOUS_OUTPUT_GATE,
  output logic [oskc_pkg::NUM_OUT-1:0] CLK_OUT,
  output logic LOCK_N,
  output logic LOOP_REINIT
);
  import oskc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [M_W-1:0] m_q, m_d;
  logic [NUM_OUT-1:0][DIV_W-1:0] v_q, v_d;
  logic [3:0][PROF_W-1:0] prof_q, prof_d;
  logic [31:0] rdata_q, rdata_d;
  oskc_rst_type rst_state_q, rst_state_d;
  logic [31:0] rst_cnt_q, rst_cnt_d;
  logic [1:0] act_prof_q, act_prof_d;
  logic [2:0] osc_ph_q, osc_ph_d;
  logic [31:0] lock_cnt_q, lock_cnt_d;
  logic lock_q, lock_d;
  logic ref_q, ref_prev_q;
  logic [M_W-1:0] mcnt_q, mcnt_d;
  logic [NUM_OUT-1:0][DIV_W-2:0] div_cnt_q, div_cnt_d;
  logic [NUM_OUT-1:0] raw_q, raw_d;
  logic [NUM_OUT-1:0] en_q, en_d;
  logic [NUM_OUT-1:0] gate_q, gate_d;
  logic [NUM_OUT-1:0] out_q, out_d;
  logic wr_en, setup, addr_hit, logic_hold, loop_hold, ev, m_pulse;
  logic [M_W-1:0] m_eff;
  logic [PROF_W-1:0] cur_prof;

  oskc_skew_if sk ();

  oskc_skew_line u_line
  (
    .MCLK(MCLK),
    .RST_N(RST_N),
    .sk(sk)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  assign setup = PSEL && !PENABLE;
  assign wr_en = PSEL && PENABLE && PWRITE && addr_hit;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit;
  assign PRDATA = rdata_q;

  // Address decode and read data prepared in the setup phase
  always_comb
  begin
    addr_hit = 1'b1;
    rdata_d = rdata_q;
    if (setup)
    begin
      rdata_d = '0;
      case (PADDR)
        REG_CTRL: rdata_d[M_W-1:0] = m_q;
        REG_VDIV:
        begin
          for (int k = 0; k < NUM_OUT; k++)
            rdata_d[k*VDIV_STRIDE +: DIV_W] = v_q[k];
        end
        REG_PROF0, REG_PROF0 + 8'h04, REG_PROF0 + 8'h08, REG_PROF0 + 8'h0c:
          rdata_d[PROF_W-1:0] = prof_q[PADDR[3:2]];
        REG_STATUS:
        begin
          rdata_d[ST_PROF_LSB +: 2] = act_prof_q;
          rdata_d[ST_LOCK_BIT] = lock_q;
          rdata_d[ST_LOOPRST_BIT] = loop_hold;
          rdata_d[ST_BYPASS_BIT] = LOOP_BYPASS;
          rdata_d[ST_LOGICRST_BIT] = logic_hold;
          rdata_d[ST_EN_LSB +: NUM_OUT] = en_q;
          rdata_d[ST_GATE_LSB +: NUM_OUT] = gate_q;
        end
        default: rdata_d = '0;
      endcase
    end
    if (PSEL)
    begin
      case (PADDR)
        REG_CTRL, REG_VDIV, REG_STATUS: addr_hit = 1'b1;
        REG_PROF0, REG_PROF0 + 8'h04, REG_PROF0 + 8'h08, REG_PROF0 + 8'h0c: addr_hit = 1'b1;
        default: addr_hit = 1'b0;
      endcase
    end
  end

  // Configuration writes; status is read only and ignores writes
  always_comb
  begin
    m_d = m_q;
    v_d = v_q;
    prof_d = prof_q;
    if (wr_en)
    begin
      case (PADDR)
        REG_CTRL: m_d = PWDATA[M_W-1:0];
        REG_VDIV:
        begin
          for (int k = 0; k < NUM_OUT; k++)
            v_d[k] = PWDATA[k*VDIV_STRIDE +: DIV_W];
        end
        REG_PROF0, REG_PROF0 + 8'h04, REG_PROF0 + 8'h08, REG_PROF0 + 8'h0c:
          prof_d[PADDR[3:2]] = PWDATA[PROF_W-1:0];
        default: m_d = m_q;
      endcase
    end
  end

  // Configuration survives the reset pin; only RST_N clears it
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      m_q <= M_RESET;
      v_q <= {NUM_OUT{V_RESET}};
      prof_q <= {4{PROF_RESET}};
      rdata_q <= '0;
    end
    else
    begin
      m_q <= m_d;
      v_q <= v_d;
      prof_q <= prof_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Reset pin width decides logic-only or full loop restart
  assign logic_hold = (rst_state_q != RS_IDLE);
  assign loop_hold = (rst_state_q == RS_LOOP);

  always_comb
  begin
    rst_state_d = rst_state_q;
    act_prof_d = act_prof_q;
    rst_cnt_d = RESET_REQ_N ? 32'h0 : rst_cnt_q + 32'h1;
    case (rst_state_q)
      RS_IDLE:
      begin
        // Shorter pulses are treated as glitches
        if (!RESET_REQ_N && rst_cnt_q == 32'(LOGIC_RST_CYC - 1))
          rst_state_d = RS_LOGIC;
      end
      RS_LOGIC:
      begin
        if (RESET_REQ_N)
        begin
          rst_state_d = RS_IDLE;
          act_prof_d = PROFILE_SELECT;
        end
        else if (rst_cnt_q == 32'(LOOP_RST_CYCLES - 1))
          rst_state_d = RS_LOOP;
      end
      RS_LOOP:
      begin
        rst_cnt_d = rst_cnt_q;
        if (RESET_REQ_N)
        begin
          rst_state_d = RS_IDLE;
          act_prof_d = PROFILE_SELECT;
        end
      end
      default: rst_state_d = RS_IDLE;
    endcase
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      rst_state_q <= RS_IDLE;
      rst_cnt_q <= '0;
      act_prof_q <= 2'h0;
    end
    else
    begin
      rst_state_q <= rst_state_d;
      rst_cnt_q <= rst_cnt_d;
      act_prof_q <= act_prof_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Oscillator phase and lock model; a full reset stops the loop
  always_comb
  begin
    osc_ph_d = loop_hold ? 3'h0 : osc_ph_q + 3'h1;
    lock_cnt_d = lock_cnt_q;
    lock_d = lock_q;
    if (loop_hold || LOOP_BYPASS)
    begin
      // No lock report while bypassed or restarting
      lock_cnt_d = '0;
      lock_d = 1'b0;
    end
    else if (lock_cnt_q == 32'(LOCK_CYCLES - 1))
      lock_d = 1'b1;
    else
      lock_cnt_d = lock_cnt_q + 32'h1;
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      osc_ph_q <= '0;
      lock_cnt_q <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      osc_ph_q <= osc_ph_d;
      lock_cnt_q <= lock_cnt_d;
      lock_q <= lock_d;
    end
  end

  assign LOCK_N = !lock_q;
  assign LOOP_REINIT = loop_hold;

  ////////////////////////////////////////////////////////////////////////////
  // Input divider and output dividers; input events move the input divider in every mode and the output dividers in bypass, oscillator phase wraps otherwise
  assign m_eff = (m_q == '0) ? M_W'(1) : m_q;
  assign m_pulse = (ref_q != ref_prev_q) && (mcnt_q + M_W'(1) >= m_eff);
  // Bypass counts both input edges, halving the nominal divide
  assign ev = LOOP_BYPASS ? m_pulse : (osc_ph_q == 3'(OSC_TICKS - 1));

  always_comb
  begin
    logic [DIV_W-2:0] half;
    half = '0;
    mcnt_d = mcnt_q;
    div_cnt_d = div_cnt_q;
    raw_d = raw_q;
    // Static chain in bypass: with no input edge nothing changes, down to 0 Hz
    if (ref_q != ref_prev_q)
      mcnt_d = m_pulse ? '0 : mcnt_q + M_W'(1);
    for (int k = 0; k < NUM_OUT; k++)
    begin
      half = (v_q[k][DIV_W-1:1] == '0) ? (DIV_W-1)'(1) : v_q[k][DIV_W-1:1];
      if (ev)
      begin
        if (div_cnt_q[k] + (DIV_W-1)'(1) >= half)
        begin
          div_cnt_d[k] = '0;
          raw_d[k] = !raw_q[k];
        end
        else
          div_cnt_d[k] = div_cnt_q[k] + (DIV_W-1)'(1);
      end
    end
    if (logic_hold)
    begin
      mcnt_d = '0;
      div_cnt_d = '0;
      raw_d = '0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      ref_q <= 1'b0;
      ref_prev_q <= 1'b0;
      mcnt_q <= '0;
      div_cnt_q <= '0;
      raw_q <= '0;
    end
    else
    begin
      ref_q <= REF_IN;
      ref_prev_q <= ref_q;
      mcnt_q <= mcnt_d;
      div_cnt_q <= div_cnt_d;
      raw_q <= raw_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Skew tap selection from the active profile
  assign cur_prof = prof_q[act_prof_q];
  assign sk.raw_clk = raw_q;

  always_comb
  begin
    for (int k = 0; k < NUM_OUT; k++)
    begin
      if (LOOP_BYPASS)
        sk.tap_sel[k] = '0;
      else if (cur_prof[PROF_COARSE_BIT])
        sk.tap_sel[k] = TAP_W'(cur_prof[k*SKEW_W +: SKEW_W]) * TAP_W'(COARSE_TICKS);
      else
        sk.tap_sel[k] = TAP_W'(cur_prof[k*SKEW_W +: SKEW_W]) * TAP_W'(FINE_TICKS);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enables, synchronous gate and output stage
  always_comb
  begin
    for (int k = 0; k < NUM_OUT; k++)
    begin
      // Two edges from pin to output, well inside the limit
      en_d[k] = GLOBAL_OUTPUT_ENABLE &&
        ((k < BANK_X_COUNT) ? BANK_X_OUTPUT_ENABLE : BANK_Y_OUTPUT_ENABLE);
      // Gate only moves while the skewed clock is low, so no runt pulses
      gate_d[k] = sk.skewed_clk[k] ? gate_q[k] : SYNCHRONOUS_OUTPUT_GATE;
      out_d[k] = sk.skewed_clk[k] && en_q[k] && gate_q[k] && !logic_hold;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      en_q <= '0;
      gate_q <= '0;
      out_q <= '0;
    end
    else
    begin
      en_q <= en_d;
      gate_q <= gate_d;
      out_q <= out_d;
    end
  end

  assign CLK_OUT = out_q;

endmodule

// ===== tb/oskc_board_model.sv
module oskc_board_model
(
  input wire logic mclk,
  output logic ref_in,
  output logic loop_bypass,
  output logic reset_req_n,
  output logic [1:0] profile_select,
  output logic [3:0] pins
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle board: loop in use, pins {bank x, bank y, global, gate} all on
  initial
  begin
    ref_in = 1'b0;
    loop_bypass = 1'b0;
    reset_req_n = 1'b1;
    profile_select = 2'h0;
    pins = 4'hf;
  end

  // Profile moves with the reset edge, so the hold runs the whole pulse
  task automatic reset_pulse(input int cyc, input logic [1:0] prof);
    @(posedge mclk);
    profile_select <= prof;
    reset_req_n <= 1'b0;
    repeat (cyc) @(posedge mclk);
    reset_req_n <= 1'b1;
  endtask

  // Three periods of a 64-tick output before anyone relies on it
  task automatic set_pins(input logic [3:0] v);
    @(posedge mclk);
    pins <= v;
    repeat (3 * 64) @(posedge mclk);
  endtask

  task automatic set_bypass(input logic b);
    @(posedge mclk);
    loop_bypass <= b;
  endtask

  // Reference runs only here; it stands still at its last level between bursts
  task automatic ref_run(input int n);
    repeat (2 * n)
    begin
      repeat (4) @(posedge mclk);
      ref_in <= !ref_in;
    end
  endtask
endmodule

// ===== tb/oskc_checker.sv
module oskc_checker
#(
  parameter int LOOP_RST_CYCLES = oskc_pkg::LOOP_RST_CYC
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic REF_IN,
  input wire logic LOOP_BYPASS,
  input wire logic RESET_REQ_N,
  input wire logic BANK_X_OUTPUT_ENABLE,
  input wire logic BANK_Y_OUTPUT_ENABLE,
  input wire logic GLOBAL_OUTPUT_ENABLE,
  input wire logic SYNCHRONOUS_OUTPUT_GATE,
  input wire logic [oskc_pkg::NUM_OUT-1:0] CLK_OUT,
  input wire logic LOOP_REINIT,
  input wire logic LOCK_N
);
  timeunit 1ns;
  timeprecision 1ps;
  import oskc_pkg::*;
  int low_q;
  int quiet_q;
  default clocking cb @(posedge MCLK);
  endclocking
  default disable iff (!RST_N);

  // Low reset-pin samples; idle bypass cycles, long enough to drain any skew tap
  always_ff @(posedge MCLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      low_q <= 0;
      quiet_q <= 0;
    end
    else
    begin
      low_q <= RESET_REQ_N ? 0 : low_q + 1;
      quiet_q <= (LOOP_BYPASS && RESET_REQ_N && $stable(REF_IN) && $stable({BANK_X_OUTPUT_ENABLE,
        BANK_Y_OUTPUT_ENABLE, GLOBAL_OUTPUT_ENABLE, SYNCHRONOUS_OUTPUT_GATE})) ? quiet_q + 1 : 0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_bank_x_off;
    !BANK_X_OUTPUT_ENABLE [*3] |-> CLK_OUT[1:0] == 2'h0;
  endproperty
  a_bank_x_off: assert property (p_bank_x_off) else $error("bank x outputs not off");
  property p_bank_y_off;
    !BANK_Y_OUTPUT_ENABLE [*3] |-> CLK_OUT[3:2] == 2'h0;
  endproperty
  a_bank_y_off: assert property (p_bank_y_off) else $error("bank y outputs not off");
  property p_global_off;
    !GLOBAL_OUTPUT_ENABLE [*3] |-> CLK_OUT == '0;
  endproperty
  a_global_off: assert property (p_global_off) else $error("outputs not off");
  property p_bypass_unlocked;
    LOOP_BYPASS [*2] |-> LOCK_N;
  endproperty
  a_bypass_unlocked: assert property (p_bypass_unlocked) else $error("lock shown in bypass");
  property p_static_hold;
    quiet_q >= 40 |-> $stable(CLK_OUT);
  endproperty
  a_static_hold: assert property (p_static_hold) else $error("output moved without input");
  property p_logic_reset;
    low_q >= 8 |-> CLK_OUT == '0;
  endproperty
  a_logic_reset: assert property (p_logic_reset) else $error("outputs run in reset");
  property p_loop_reinit;
    low_q >= LOOP_RST_CYCLES + 2 |-> LOOP_REINIT && LOCK_N;
  endproperty
  a_loop_reinit: assert property (p_loop_reinit) else $error("long pulse missed");
  property p_short_pulse;
    low_q >= 3 && low_q <= LOOP_RST_CYCLES - 3 |-> !LOOP_REINIT;
  endproperty
  a_short_pulse: assert property (p_short_pulse) else $error("short pulse reset loop");
endmodule

bind oskc_top oskc_checker #(.LOOP_RST_CYCLES(LOOP_RST_CYCLES)) u_oskc_checker
(
  .MCLK(MCLK),
  .RST_N(RST_N),
  .REF_IN(REF_IN),
  .LOOP_BYPASS(LOOP_BYPASS),
  .RESET_REQ_N(RESET_REQ_N),
  .BANK_X_OUTPUT_ENABLE(BANK_X_OUTPUT_ENABLE),
  .BANK_Y_OUTPUT_ENABLE(BANK_Y_OUTPUT_ENABLE),
  .GLOBAL_OUTPUT_ENABLE(GLOBAL_OUTPUT_ENABLE),
  .SYNCHRONOUS_OUTPUT_GATE(SYNCHRONOUS_OUTPUT_GATE),
  .CLK_OUT(CLK_OUT),
  .LOOP_REINIT(LOOP_REINIT),
  .LOCK_N(LOCK_N)
);

// ===== tb/test_output_skew_and_gating_control.sv
module test_output_skew_and_gating_control;
  timeunit 1ns;
  timeprecision 1ps;
  import oskc_pkg::*;
  localparam int LRC = 40;
  localparam int LKC = 20;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, ref_in, loop_bypass, reset_req_n, lock_n, loop_reinit;
  logic [1:0] profile_select;
  logic [3:0] pins;
  logic [NUM_OUT-1:0] clk_out;
  logic [31:0] regs [logic [7:0]];
  logic [31:0] pv [4];
  int rise [NUM_OUT];
  logic [3:0] tog;
  int n0, t, tg;
  int fail_count = 0;
  int compares = 0;

  always #2.5 mclk = !mclk;

  oskc_top #(.LOOP_RST_CYCLES(LRC), .LOCK_CYCLES(LKC)) u_oskc_top
  (
    .MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
    .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .REF_IN(ref_in),
    .LOOP_BYPASS(loop_bypass), .RESET_REQ_N(reset_req_n), .PROFILE_SELECT(profile_select),
    .BANK_X_OUTPUT_ENABLE(pins[3]), .BANK_Y_OUTPUT_ENABLE(pins[2]), .GLOBAL_OUTPUT_ENABLE(pins[1]),
    .SYNCHRONOUS_OUTPUT_GATE(pins[0]), .CLK_OUT(clk_out), .LOCK_N(lock_n), .LOOP_REINIT(loop_reinit)
  );
  oskc_board_model u_oskc_board_model
  (
    .mclk(mclk), .ref_in(ref_in), .loop_bypass(loop_bypass), .reset_req_n(reset_req_n),
    .profile_select(profile_select), .pins(pins)
  );

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic close_out;
    $display("%0d compares, %0d mismatches", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic timeout;
    fail_count++;
    $display("[ERR] %0t wait ran out", $time);
    close_out();
  endtask

  // One APB transfer checked against the register model; status data is live, so not compared
  task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    i = 0;
    @(posedge mclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge mclk);
    penable <= 1'b1;
    do
    begin
      @(posedge mclk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    if (pready !== 1'b1)
      timeout();
    cmp(32'(pslverr), 32'(!(regs.exists(a) || a == REG_STATUS)));
    if (!wr && a != REG_STATUS)
      cmp(prdata, regs.exists(a) ? regs[a] : 32'h0);
    if (wr && regs.exists(a))
      regs[a] = d;
    {psel, penable} <= 2'b00;
  endtask

  // Rise offsets from output 0, outputs that moved, rises of output 0
  task automatic watch(input int cyc);
    logic [3:0] p;
    int t0;
    t0 = -1;
    tog = 4'h0;
    n0 = 0;
    rise = '{default: -1};
    #1;
    p = clk_out;
    for (int c = 0; c < cyc; c++)
    begin
      @(posedge mclk);
      #1;
      tog |= clk_out ^ p;
      if (clk_out[0] && !p[0])
        n0++;
      if (t0 < 0 && clk_out[0] && !p[0])
        t0 = c;
      foreach (rise[k])
        if (t0 >= 0 && rise[k] < 0 && clk_out[k] && !p[k])
          rise[k] = c - t0;
      p = clk_out;
    end
  endtask

  task automatic wait_lock;
    for (t = 0; lock_n !== 1'b0; t++)
    begin
      @(posedge mclk);
      #1;
      if (t > 500)
        timeout();
    end
  endtask

  initial
  begin
    void'($urandom(74496));
    regs[REG_CTRL] = 32'(M_RESET);
    regs[REG_VDIV] = {4{1'b0, V_RESET}};
    for (int p = 0; p < 4; p++)
      regs[REG_PROF0 + 8'(4 * p)] = 32'(PROF_RESET);
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (regs[a])
      acc(1'b0, a, 32'h0);
    acc(1'b1, 8'h08, 32'h1);
    acc(1'b0, 8'h08, 32'h0);
    acc(1'b1, REG_STATUS, 32'hffff);
    acc(1'b1, REG_VDIV, 32'($urandom()) & 32'h7f7f7f7f);
    acc(1'b0, REG_VDIV, 32'h0);
    $display("register test done");
    acc(1'b1, REG_CTRL, 32'h1);
    acc(1'b1, REG_VDIV, 32'h08080808);
    foreach (pv[p])
    begin
      pv[p] = {15'h0, p[0], 12'($urandom()), 4'h0};
      if (p > 1)
        pv[p][15:12] = 4'hf;
      acc(1'b1, REG_PROF0 + 8'(4 * p), pv[p]);
      acc(1'b0, REG_PROF0 + 8'(4 * p), 32'h0);
    end
    foreach (pv[p])
    begin
      u_oskc_board_model.reset_pulse(6, 2'(p));
      watch(400);
      foreach (rise[k])
        cmp(32'(rise[k]), 32'(pv[p][4*k+:4] * (pv[p][16] ? COARSE_TICKS : FINE_TICKS)));
      // Profile taken at the release, loop still locked after a short pulse
      acc(1'b0, REG_STATUS, 32'h0);
      cmp(prdata, (32'(p) << ST_PROF_LSB) | (32'h1 << ST_LOCK_BIT) | (32'h0f << ST_EN_LSB) | (32'h0f << ST_GATE_LSB));
    end
    $display("skew test done");
    for (int c = 0; c < 16; c++)
    begin
      u_oskc_board_model.set_pins(4'(c));
      watch(70);
      cmp(32'(tog), 32'((c[1] && c[0]) ? {c[2], c[2], c[3], c[3]} : 4'h0));
    end
    $display("enable test done");
    acc(1'b1, REG_CTRL, 32'h2);
    acc(1'b1, REG_VDIV, 32'h04040404);
    u_oskc_board_model.set_bypass(1'b1);
    u_oskc_board_model.reset_pulse(6, 2'h0);
    tg = 2 * 30 / (2 * 4 / 2);
    fork
      u_oskc_board_model.ref_run(30);
      watch(260);
    join
    cmp(32'(n0), 32'((tg + 1) / 2));
    watch(200);
    cmp(32'(tog), 32'h0);
    cmp(32'(clk_out), (tg % 2) ? 32'hf : 32'h0);
    cmp(32'(lock_n), 32'h1);
    // Bypass shows in status with no lock and no reset pending
    acc(1'b0, REG_STATUS, 32'h0);
    cmp(prdata, (32'h1 << ST_BYPASS_BIT) | (32'h0f << ST_EN_LSB) | (32'h0f << ST_GATE_LSB));
    tg = 2 * 32 / (2 * 4 / 2);
    u_oskc_board_model.ref_run(2);
    watch(20);
    cmp(32'(clk_out), (tg % 2) ? 32'hf : 32'h0);
    $display("bypass test done");
    u_oskc_board_model.set_bypass(1'b0);
    wait_lock();
    u_oskc_board_model.reset_pulse(10, 2'h0);
    #1;
    cmp(32'({lock_n, loop_reinit}), 32'h0);
    fork
      u_oskc_board_model.reset_pulse(LRC + 5, 2'h0);
      begin
        repeat (LRC + 4) @(posedge mclk);
        #1;
        cmp(32'({lock_n, loop_reinit}), 32'h3);
      end
    join
    wait_lock();
    cmp(32'(t >= LKC - 1 && t <= LKC + 4), 32'h1);
    $display("reset test done");
    close_out();
  end
endmodule
